// >>> logic/slfc_codec.sv
// serial link frame codec: 28-bit frame encoder and aligning decoder
// assumes a serdes phy shifts tx_frame out and delivers rx_frame words,
// all on pclk, and an apb master for the control registers
//
// What this block does
// - 24 data plus 3 controls per cycle
// - each cycle becomes one 28-bit frame
// - line rate is 28 times pclk
// - high mark one, low mark zero
// - payload carries scrambled data only
// - invert bit limits running dc bias
// - integrity bit checks frame, carries controls
// - both codings made and undone here
// - lock on markers, no training patterns
// - align, validate, then deserialise frames
// - map select picks msb or lsb lane
// - register can override map select pin
// - output off drops lock, relock first
// - relock after power-down before valid frames
// - lock timer at most 10 ms
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "slfc_cfg.svh"
module slfc_codec import slfc_pkg::*; #(
   parameter int LOCK_CYCLES = `SLFC_LOCK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic lane_map_select,
   input wire logic power_down_n,
   input wire slfc_par_t par_in,
   output logic [27:0] tx_frame,
   output logic tx_frame_valid,
   output logic serial_oe,
   input wire logic [27:0] rx_frame,
   output slfc_par_t rx_par,
   output logic rx_valid,
   output logic rx_lock
);
   // ==========================================
   // functions
   // lsb mode reverses the four 6-bit lane groups; it is its own inverse
   function automatic logic [23:0] lane_map(input logic [23:0] d, input logic msb);
      logic [23:0] r;
      r = d;
      if (!msb) begin
         for (int g = 0; g < 4; g++) begin
            r[g*6 +: 6] = d[(3-g)*6 +: 6];
         end
      end
      return r;
   endfunction

   // self-synchronising mix of the previous scrambled word
   function automatic logic [23:0] mix(input logic [23:0] x);
      return {x[17:0], x[23:18]} ^ {x[4:0], x[23:5]};
   endfunction

   function automatic logic [4:0] ones(input logic [23:0] x);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < 24; i++) begin
         n = n + {4'h0, x[i]};
      end
      return n;
   endfunction

   // control bit chosen by the low payload bits; slot 3 is pure parity
   function automatic logic ctl_pick(input logic [2:0] c, input logic [1:0] idx);
      return (idx == `SLFC_IDX_PARITY) ? 1'b0 : c[idx];
   endfunction

   // ==========================================
   // state
   slfc_state_t s_r; // registered state
   slfc_state_t s_nxt; // next state
   logic pd_active; // pin or software power-down
   logic map_msb; // effective lane map
   logic [23:0] tx_data; // mapped input payload
   logic [23:0] tx_scr; // scrambled payload
   logic [4:0] tx_ones; // ones in scrambled payload
   logic tx_inv; // balance decision
   logic [23:0] tx_pay; // payload as sent
   logic [55:0] rx_win; // two received words
   logic [27:0] rx_cand; // frame at candidate offset
   logic rx_mark_ok; // markers in place
   logic rx_par_ok; // parity check, only in slot 3
   logic [23:0] rx_scr; // received payload, un-inverted
   logic apb_wr; // write access phase
   logic apb_hit; // address is mapped

   // ==========================================
   // combinational helpers
   always_comb begin
      pd_active = !power_down_n || s_r.ctrl[`SLFC_CTRL_SOFT_PD];
      // register override beats the pin
      map_msb = s_r.ctrl[`SLFC_CTRL_MAP_OVR] ? s_r.ctrl[`SLFC_CTRL_MAP_VAL]
                                             : lane_map_select;
      tx_data = lane_map(par_in.data, map_msb);
      tx_scr = tx_data ^ mix(s_r.tx_scr_prev);
      tx_ones = ones(tx_scr);
      // invert when the word would push the bias further the same way
      if (s_r.disparity > 10'sh000) begin
         tx_inv = tx_ones > `SLFC_PAY_HALF;
      end else if (s_r.disparity < 10'sh000) begin
         tx_inv = tx_ones < `SLFC_PAY_HALF;
      end else begin
         tx_inv = 1'b0;
      end
      tx_pay = tx_inv ? ~tx_scr : tx_scr;
      rx_win = {rx_frame, s_r.rx_prev};
      rx_cand = rx_win[s_r.rx_offset +: 28];
      rx_mark_ok = rx_cand[`SLFC_MARK_HI] && !rx_cand[`SLFC_MARK_LO];
      rx_par_ok = (rx_cand[4:3] != `SLFC_IDX_PARITY) ||
                  !(^rx_cand[`SLFC_PAY_HI:`SLFC_INTEG]);
      rx_scr = rx_cand[`SLFC_BAL] ? ~rx_cand[`SLFC_PAY_HI:`SLFC_PAY_LO]
                                  : rx_cand[`SLFC_PAY_HI:`SLFC_PAY_LO];
      apb_wr = psel && penable && pwrite;
      apb_hit = (paddr == `SLFC_OFF_CTRL) || (paddr == `SLFC_OFF_STATUS) ||
                (paddr == `SLFC_OFF_ERRCNT);
   end

   // ==========================================
   // next state
   always_comb begin
      logic [4:0] ones_tx;
      logic [2:0] ctl;
      logic [2:0] rx_ctl;
      logic rx_err;
      ones_tx = 5'h00;
      ctl = {par_in.de, par_in.vs, par_in.hs};
      rx_ctl = {s_r.rx_par.de, s_r.rx_par.vs, s_r.rx_par.hs};
      rx_err = 1'b0;
      s_nxt = s_r;
      // ---- encoder: marks, payload, balance, integrity
      s_nxt.tx_frame[`SLFC_MARK_HI] = 1'b1;
      s_nxt.tx_frame[`SLFC_MARK_LO] = 1'b0;
      s_nxt.tx_frame[`SLFC_PAY_HI:`SLFC_PAY_LO] = tx_pay;
      s_nxt.tx_frame[`SLFC_BAL] = tx_inv;
      // parity over payload and balance bit, folded with one control
      s_nxt.tx_frame[`SLFC_INTEG] = (^tx_pay) ^ tx_inv ^ ctl_pick(ctl, tx_pay[1:0]);
      s_nxt.tx_scr_prev = tx_scr;
      ones_tx = tx_inv ? (5'h18 - tx_ones) : tx_ones;
      s_nxt.disparity = s_r.disparity + $signed({4'h0, ones_tx, 1'b0}) - `SLFC_PAY_BITS;
      // ---- power-down exit lock timer
      if (pd_active) begin
         s_nxt.lock_cnt = 20'h00000;
         s_nxt.tx_locked = 1'b0;
      end else if (!s_r.tx_locked) begin
         if (s_r.lock_cnt == 20'(LOCK_CYCLES - 1)) begin
            s_nxt.tx_locked = 1'b1;
         end else begin
            s_nxt.lock_cnt = s_r.lock_cnt + 20'h00001;
         end
      end
      // ---- decoder: hunt for marker alignment, then track
      s_nxt.rx_prev = rx_frame;
      if (!s_r.rx_locked) begin
         if (rx_mark_ok && rx_par_ok) begin
            s_nxt.rx_good = s_r.rx_good + 4'h1;
            if (s_r.rx_good == `SLFC_LOCK_FRAMES - 4'h1) begin
               s_nxt.rx_locked = 1'b1;
               s_nxt.rx_miss = 4'h0;
            end
         end else begin
            // slide one bit; random data cannot hold the marks for long
            s_nxt.rx_good = 4'h0;
            s_nxt.rx_offset = (s_r.rx_offset == `SLFC_LAST_OFFSET) ? 5'h00
                              : s_r.rx_offset + 5'h01;
         end
      end else if (rx_mark_ok) begin
         s_nxt.rx_miss = 4'h0;
      end else begin
         s_nxt.rx_miss = s_r.rx_miss + 4'h1;
         if (s_r.rx_miss == `SLFC_MISS_LIMIT - 4'h1) begin
            s_nxt.rx_locked = 1'b0;
            s_nxt.rx_good = 4'h0;
         end
      end
      // ---- decoder: descramble and pick up controls
      s_nxt.rx_scr_prev = rx_scr;
      s_nxt.rx_par.data = lane_map(rx_scr ^ mix(s_r.rx_scr_prev), map_msb);
      s_nxt.rx_par.spare = 1'b0;
      if (rx_cand[4:3] != `SLFC_IDX_PARITY) begin
         rx_ctl[rx_cand[4:3]] = ^rx_cand[`SLFC_PAY_HI:`SLFC_INTEG];
      end
      {s_nxt.rx_par.de, s_nxt.rx_par.vs, s_nxt.rx_par.hs} = rx_ctl;
      rx_err = s_r.rx_locked && !rx_par_ok;
      s_nxt.rx_valid = s_r.rx_locked && rx_mark_ok && rx_par_ok;
      // ---- apb: read data caught in setup, writes in access
      if (psel && !penable) begin
         case (paddr)
            `SLFC_OFF_CTRL: s_nxt.prdata = {28'h0000000, s_r.ctrl};
            `SLFC_OFF_STATUS: s_nxt.prdata = {28'h0000000, map_msb, pd_active,
                                              s_r.rx_locked, s_r.tx_locked};
            `SLFC_OFF_ERRCNT: s_nxt.prdata = {16'h0000, s_r.err_cnt};
            default: s_nxt.prdata = 32'h00000000;
         endcase
      end
      if (apb_wr && paddr == `SLFC_OFF_CTRL) begin
         s_nxt.ctrl = pwdata[3:0];
      end
      // a failure in the clearing cycle still counts
      if (apb_wr && paddr == `SLFC_OFF_ERRCNT) begin
         s_nxt.err_cnt = {15'h0000, rx_err};
      end else if (rx_err && s_r.err_cnt != 16'hffff) begin
         s_nxt.err_cnt = s_r.err_cnt + 16'h0001;
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.tx_frame <= `SLFC_FRAME_RESET;
         s_r.ctrl <= `SLFC_CTRL_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================
   // outputs
   always_comb begin
      prdata = s_r.prdata;
      pready = 1'b1; // zero wait states
      pslverr = psel && penable && !apb_hit;
      tx_frame = s_r.tx_frame;
      // output stage off also stops valid frames; far end must relock
      serial_oe = s_r.ctrl[`SLFC_CTRL_OUT_EN] && !pd_active;
      tx_frame_valid = s_r.tx_locked && serial_oe;
      rx_par = s_r.rx_par;
      rx_valid = s_r.rx_valid;
      rx_lock = s_r.rx_locked;
   end

   // ==========================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_marks;
      tx_frame[`SLFC_MARK_HI] && !tx_frame[`SLFC_MARK_LO];
   endproperty
   a_marks: assert property (p_marks) else $error("frame marks wrong");

   property p_scrambled;
      presetn |=> (tx_frame[2] ? ~tx_frame[26:3] : tx_frame[26:3]) ==
               ($past(tx_data) ^ mix($past(s_r.tx_scr_prev)));
   endproperty
   a_scrambled: assert property (p_scrambled) else $error("payload not scrambled");

   property p_balance;
      (s_r.disparity > 10'sh000 && tx_ones > `SLFC_PAY_HALF) |=> tx_frame[2];
   endproperty
   a_balance: assert property (p_balance) else $error("bias not corrected");

   property p_integrity;
      presetn |=> (^tx_frame[26:1]) ==
               ctl_pick($past({par_in.de, par_in.vs, par_in.hs}), tx_frame[4:3]);
   endproperty
   a_integrity: assert property (p_integrity) else $error("integrity bit wrong");

   property p_pd_unlock;
      pd_active |=> !s_r.tx_locked && !tx_frame_valid;
   endproperty
   a_pd_unlock: assert property (p_pd_unlock) else $error("lock kept in power-down");

   property p_lock_time;
      (!pd_active && !s_r.tx_locked && s_r.lock_cnt == 20'(LOCK_CYCLES - 1))
         |=> s_r.tx_locked;
   endproperty
   a_lock_time: assert property (p_lock_time) else $error("lock timer late");

   property p_oe_valid;
      !serial_oe |-> !tx_frame_valid;
   endproperty
   a_oe_valid: assert property (p_oe_valid) else $error("valid with output off");

   property p_rx_lock;
      (!rx_lock && rx_mark_ok && rx_par_ok)[*8] |=> rx_lock;
   endproperty
   a_rx_lock: assert property (p_rx_lock) else $error("no lock after good frames");

   property p_rx_drop;
      (rx_lock && !rx_mark_ok)[*4] |=> !rx_lock && !rx_valid;
   endproperty
   a_rx_drop: assert property (p_rx_drop) else $error("lock kept on lost marks");

   property p_rx_invalid;
      !rx_lock |=> !rx_valid;
   endproperty
   a_rx_invalid: assert property (p_rx_invalid) else $error("valid while hunting");

endmodule

// >>> logic/slfc_cfg.svh
// constants of the serial link frame codec: offsets, bit fields, timing
// assumes inclusion by name from the package and the codec module
`ifndef SLFC_CFG_SVH
`define SLFC_CFG_SVH
// ==========================================
// clock and timing
`define SLFC_CLK_HZ 25000000
`define SLFC_FRAME_BITS 28
`define SLFC_SERIAL_BPS (`SLFC_FRAME_BITS * `SLFC_CLK_HZ)
`define SLFC_LOCK_TIME_MS 10
`define SLFC_LOCK_CYCLES ((`SLFC_LOCK_TIME_MS * `SLFC_CLK_HZ) / 1000)
`define SLFC_LOCK_FRAMES 4'h8
`define SLFC_MISS_LIMIT 4'h4
// ==========================================
// frame layout
`define SLFC_MARK_HI 27
`define SLFC_MARK_LO 0
`define SLFC_PAY_HI 26
`define SLFC_PAY_LO 3
`define SLFC_BAL 2
`define SLFC_INTEG 1
`define SLFC_PAY_HALF 5'h0c
`define SLFC_PAY_BITS 10'sh018
`define SLFC_IDX_PARITY 2'h3
`define SLFC_LAST_OFFSET 5'h1b
`define SLFC_FRAME_RESET 28'h8000000
// ==========================================
// register map and fields
`define SLFC_OFF_CTRL 12'h000
`define SLFC_OFF_STATUS 12'h004
`define SLFC_OFF_ERRCNT 12'h008
`define SLFC_CTRL_MAP_OVR 0
`define SLFC_CTRL_MAP_VAL 1
`define SLFC_CTRL_SOFT_PD 2
`define SLFC_CTRL_OUT_EN 3
`define SLFC_CTRL_RESET 4'h8
`endif

// >>> logic/slfc_pkg.sv
// types shared by the serial link frame codec
// assumes slfc_cfg.svh sits beside it
package slfc_pkg;
   `include "slfc_cfg.svh"
   // ==========================================
   // parallel lanes: spare, control, payload
   typedef struct packed {
      logic spare; // unused position, host drives a level
      logic de; // video data enable
      logic vs; // vertical sync
      logic hs; // horizontal sync
      logic [23:0] data; // pixel payload
   } slfc_par_t;
   // ==========================================
   // whole state of the codec
   typedef struct packed {
      logic [27:0] tx_frame; // frame handed to the serialiser
      logic [23:0] tx_scr_prev; // last scrambled word sent
      logic signed [9:0] disparity; // running ones minus zeros
      logic [19:0] lock_cnt; // power-up lock timer
      logic tx_locked; // frames may be flagged valid
      logic [27:0] rx_prev; // previous received word
      logic [4:0] rx_offset; // candidate frame alignment
      logic [3:0] rx_good; // consecutive good frames while hunting
      logic [3:0] rx_miss; // consecutive misses while locked
      logic rx_locked; // receiver aligned
      logic [23:0] rx_scr_prev; // last scrambled word received
      slfc_par_t rx_par; // decoded lanes
      logic rx_valid; // decoded lanes carry a good frame
      logic [3:0] ctrl; // software control bits
      logic [15:0] err_cnt; // integrity failures seen
      logic [31:0] prdata; // apb read data
   } slfc_state_t;
endpackage

// >>> tb/slfc_link_model.sv
// far side of the codec: the serial line looped back to the receiver
// assumes one pclk domain; slip sets the bit alignment seen at the receiver
`timescale 1ns/1ps
module slfc_link_model (
   input wire logic pclk,
   input wire logic serial_oe,
   input wire logic [4:0] slip,
   input wire logic flip_en,
   input wire logic [27:0] tx_frame,
   output logic [27:0] rx_frame
);
   // ==========
   // line history
   logic [27:0] prev_r = 28'h0; // word sent one cycle earlier
   logic tog_r = 1'b0; // floating line level, changes every cycle
   // history registers, no reset: the line has none
   always @(posedge pclk) begin
      prev_r <= tx_frame;
      tog_r <= ~tog_r;
   end
   // ==========
   // line view at the receiver
   // an undriven line never repeats the last frame, so markers cannot survive at offset 0; at other offsets they pass every other cycle
   always_comb begin
      rx_frame = serial_oe ? 28'({tx_frame, prev_r} >> slip) : {28{tog_r}};
      // corrupt a payload bit of parity-only frames on command
      if (flip_en && rx_frame[4:3] == 2'h3)
         rx_frame[10] = ~rx_frame[10];
   end
endmodule

// >>> tb/tb_top.sv
// self-checking bench of slfc_codec against a behavioural frame model
// assumes the package, the codec and slfc_link_model are compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin fails++; \
   $display("mismatch %s exp %h got %h", nm, ex, ac); end end
module tb_top import slfc_pkg::*; ;
   // ==========
   // signals
   localparam int LOCK = 16; // short lock timer keeps the run brief
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic lane_map_select = 1'b1; // msb lanes
   logic power_down_n = 1'b1;
   logic flip_en = 1'b0; // partner corrupts parity-only frames
   logic [4:0] slip = 5'h05; // misalignment on the line
   logic [2:0] ctl_in = 3'h5; // de, vs, hs held steady until changed to 3'h2 while locked
   slfc_par_t par_in = '0;
   slfc_par_t rx_par;
   logic [27:0] tx_frame, rx_frame, exp_f;
   logic tx_frame_valid, serial_oe, rx_valid, rx_lock, inv, hit;
   logic tx_chk = 1'b0;
   logic rx_chk = 1'b0;
   logic [3:0] ctl_m = 4'h8; // bench copy of the control register
   logic [3:0] ctl3;
   logic [23:0] scr_m, sent, md;
   logic [23:0] q[$]; // recent payloads, covers decode latency
   logic [8:0] mp[4] = '{9'h079, 9'h16b, 9'h068, 9'h178}; // status, pin, ctrl
   int fails = 0, cmp_count = 0, cyc = 0, disp = 0, nerr = 0, n, k;
   always #20 pclk = ~pclk; // 25 MHz
   slfc_codec #(.LOCK_CYCLES(LOCK)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .lane_map_select, .power_down_n, .par_in,
      .tx_frame, .tx_frame_valid, .serial_oe, .rx_frame, .rx_par, .rx_valid, .rx_lock);
   slfc_link_model link (.pclk, .serial_oe, .slip, .flip_en, .tx_frame, .rx_frame);
   // random payload every cycle, spare lane held at a level
   always @(posedge pclk) par_in <= {1'b0, ctl_in, 24'($urandom)};
   // ==========
   // encoder model: map, scramble, balance, parity
   function automatic logic [23:0] mix(input logic [23:0] x);
      return {x[17:0], x[23:18]} ^ {x[4:0], x[23:5]};
   endfunction
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scr_m = 24'h0;
         disp = 0;
      end else begin
         md = par_in.data;
         if (!(ctl_m[0] ? ctl_m[1] : lane_map_select))
            md = {md[5:0], md[11:6], md[17:12], md[23:18]};
         scr_m = md ^ mix(scr_m);
         n = $countones(scr_m);
         inv = (disp > 0 && n > 12) || (disp < 0 && n < 12);
         sent = inv ? ~scr_m : scr_m;
         disp = disp + 2 * $countones(sent) - 24;
         ctl3 = {1'b0, par_in.de, par_in.vs, par_in.hs};
         exp_f = {1'b1, sent, inv, ^sent ^ inv ^ ctl3[sent[1:0]], 1'b0};
         q.push_back(par_in.data);
         if (q.size() > 6)
            void'(q.pop_front());
      end
   end
   // ==========
   // per-cycle comparisons and hang guard
   always @(negedge pclk) begin
      cyc++;
      if (tx_chk)
         `CHK("tx_frame", exp_f, tx_frame)
      if (psel && penable)
         `CHK("pready", 1'b1, pready)
      // count exactly the words that the line corrupts
      if (flip_en && rx_frame[4:3] == 2'h3)
         nerr++;
      if (rx_chk && rx_valid) begin
         hit = 1'b0;
         foreach (q[i])
            if (q[i] === rx_par.data)
               hit = 1'b1;
         `CHK("rx_data", 1'b1, hit)
         `CHK("rx_spare", 1'b0, rx_par.spare)
      end
      if (cyc > 20000) begin
         fails++;
         end_sim();
      end
   end
   // ==========
   // bus and wait helpers
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // ends at the first edge with pready high; the bench timeout guards a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (w && a == 12'h0)
         ctl_m <= d[3:0];
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      `CHK("prdata", ex, rd)
   endtask
   // bounded wait on receiver lock or transmit valid reaching lvl, cycles in k
   task automatic wait_on(input bit rx, input bit lvl = 1'b1);
      k = 0;
      while ((rx ? rx_lock : tx_frame_valid) !== lvl && k < 400) begin
         @(negedge pclk);
         k++;
      end
   endtask
   task automatic end_sim;
      if (fails == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ==========
   // main sequence
   initial begin
      void'($urandom(32'h1acd));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      tx_chk <= 1'b1;
      wait_on(1'b0);
      `CHK("tx_lock_time", 1'b1, k >= LOCK - 3 && k <= LOCK + 2)
      rchk(12'h000, 32'h8);
      apb(1'b1, 12'h00c, 32'hffff_ffff);
      `CHK("pslverr", 1'b1, err)
      rchk(12'h00c, 32'h0);
      wait_on(1'b1);
      `CHK("rx_lock", 1'b1, rx_lock)
      rx_chk <= 1'b1;
      repeat (40) @(negedge pclk);
      `CHK("rx_ctl", 3'h5, {rx_par.de, rx_par.vs, rx_par.hs})
      @(posedge pclk);
      ctl_in <= 3'h2; // controls change while locked
      repeat (40) @(negedge pclk);
      `CHK("rx_ctl_new", 3'h2, {rx_par.de, rx_par.vs, rx_par.hs})
      rx_chk <= 1'b0;
      apb(1'b1, 12'h004, 32'h0);
      rchk(12'h004, 32'hb);
      // pin alone at both levels, and register override against the pin both ways
      foreach (mp[i]) begin
         @(posedge pclk);
         lane_map_select <= mp[i][4];
         apb(1'b1, 12'h000, {28'h0, mp[i][3:0]});
         repeat (6) @(negedge pclk);
         rchk(12'h004, {28'h0, mp[i][8:5]});
      end
      // realign, then corrupt parity-only frames
      @(posedge pclk);
      slip <= 5'h00;
      // old alignment may survive a few frames by chance; wait for the drop
      wait_on(1'b1, 1'b0);
      `CHK("slip_drop", 1'b0, rx_lock)
      wait_on(1'b1);
      `CHK("slip_relock", 1'b1, rx_lock)
      apb(1'b1, 12'h008, 32'h0);
      nerr = 0;
      @(posedge pclk);
      flip_en <= 1'b1;
      repeat (24) @(posedge pclk);
      flip_en <= 1'b0;
      repeat (6) @(negedge pclk);
      rchk(12'h008, 32'(nerr));
      apb(1'b1, 12'h008, 32'h1);
      rchk(12'h008, 32'h0);
      // output off drops the link, then relock
      apb(1'b1, 12'h000, 32'h0);
      @(negedge pclk);
      `CHK("serial_oe", 1'b0, serial_oe)
      `CHK("tx_valid", 1'b0, tx_frame_valid)
      repeat (10) @(negedge pclk);
      `CHK("rx_lock_off", 1'b0, rx_lock)
      `CHK("rx_valid_off", 1'b0, rx_valid)
      apb(1'b1, 12'h000, 32'h8);
      wait_on(1'b1);
      `CHK("relock", 1'b1, rx_lock)
      // software power-down: output off, both locks lost, then timed relock
      apb(1'b1, 12'h000, 32'hc);
      repeat (10) @(negedge pclk);
      rchk(12'h004, 32'hc);
      apb(1'b1, 12'h000, 32'h8);
      wait_on(1'b0);
      `CHK("soft_pd_lock", 1'b1, k >= LOCK - 3 && k <= LOCK + 2)
      // power-down and timed recovery
      tx_chk <= 1'b0;
      @(posedge pclk);
      power_down_n <= 1'b0;
      repeat (3) @(negedge pclk);
      `CHK("pd_oe", 1'b0, serial_oe)
      @(posedge pclk);
      power_down_n <= 1'b1;
      wait_on(1'b0);
      `CHK("pd_lock_time", 1'b1, k >= LOCK - 3 && k <= LOCK + 2)
      end_sim();
   end
endmodule
